// ===== include/prog_mem_map.vh
// constants for the program memory map and security block
`ifndef PROG_MEM_MAP_VH
`define PROG_MEM_MAP_VH
`define SEC_NONE        2'h0
`define SEC_ROM         2'h1
`define SEC_ROMRAM      2'h2
`define HPW_NONE        2'h0
`define HPW_DENY        2'h1
`define HPW_WIN_A       2'h2
`define HPW_WIN_B       2'h3
`define HPW_A_LO        16'h1000
`define HPW_A_HI        16'h17FF
`define HPW_B_LO        16'h4000
`define HPW_B_HI        16'h5FFF
`define SECURE_FILL     16'hFFFF
`define VEC_RESET_PAGE  9'h1FF
`define VEC_SLOT_BITS   2
`define VEC_NUM_BITS    5
`define TEST_LO         16'hFF00
`define TEST_HI         16'hFF7F
`define RAM_ALIAS_HI    16'h7FFF
`define ORG_EXT         2'h0
`define ORG_ROM         2'h1
`define ORG_RAM         2'h2
`define OP_NONE         3'h0
`define OP_FB           3'h1
`define OP_FBACC        3'h2
`define OP_FCALA        3'h3
`define OP_FCALL        3'h4
`define OP_FRET         3'h5
`define OP_FRETE        3'h6
`define MODE_RAM_OVERLAY_ENABLE_BIT   5
`define MODE_MP_BIT     6
`define MODE_ROM_IN_DATA_SPACE_BIT   3
`define MODE_VECTOR_PAGE_POINTER_LSB   7
`define MODE_RST        16'hFF80
`endif

// ===== logic/prog_mem_map.v
// program memory map, security checker, vector pointer and far-transfer paging
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`include "prog_mem_map.vh"
module prog_mem_map #(
	parameter PAGE_BITS = 7,
	parameter ROM_LO    = 16'hC000,
	parameter SINGLE_ACCESS_RAM_LO  = 16'h0080,
	parameter SINGLE_ACCESS_RAM_HI  = 16'h7FFF,
	parameter DUAL_ACCESS_RAM_LO  = 16'h0080,
	parameter DUAL_ACCESS_RAM_HI  = 16'h3FFF,
	parameter SHR_LO    = 16'h8000,
	parameter SHR_HI    = 16'hBFFF
) (
	input  wire                   i_clock,
	input  wire                   i_srst,
	input  wire [1:0]             i_security_option,
	input  wire [1:0]             i_host_window_sel,
	input  wire                   i_micro_mode_select,
	input  wire                   i_mode_wr,
	input  wire [15:0]            i_mode_wdata,
	input  wire                   i_mode_rd,
	input  wire                   i_page_wr,
	input  wire [PAGE_BITS-1:0]   i_page_wdata,
	input  wire                   i_page_rd,
	input  wire                   i_fetch_req,
	input  wire [15:0]            i_fetch_addr,
	input  wire                   i_vector_take,
	input  wire [`VEC_NUM_BITS-1:0] i_vector_num,
	input  wire                   i_hw_reset_vector,
	input  wire [2:0]             i_far_op,
	input  wire                   i_far_delayed,
	input  wire [PAGE_BITS+15:0]  i_far_target,
	input  wire [PAGE_BITS+15:0]  i_acc_a,
	input  wire [PAGE_BITS+15:0]  i_return_addr,
	input  wire                   i_prog_data_rd,
	input  wire                   i_prog_data_wr,
	input  wire                   i_data_rd,
	input  wire [15:0]            i_data_addr,
	input  wire [15:0]            i_mem_rdata,
	input  wire                   i_host_rd,
	input  wire                   i_host_wr,
	input  wire [15:0]            i_host_addr,
	input  wire [15:0]            i_host_mem_rdata,
	input  wire                   i_core1_req,
	input  wire [15:0]            i_core1_addr,
	input  wire                   i_core2_req,
	input  wire [15:0]            i_core2_addr,
	input  wire                   i_emu_req,
	output reg  [15:0]            o_mode_rdata,
	output reg  [PAGE_BITS-1:0]   o_page_rdata,
	output reg  [PAGE_BITS+15:0]  o_prog_addr,
	output reg                    o_prog_onchip,
	output reg                    o_prog_external,
	output reg                    o_prog_is_rom,
	output reg                    o_prog_is_ram,
	output reg                    o_pc_load,
	output reg  [PAGE_BITS+15:0]  o_pc_value,
	output reg                    o_pc_load_delayed,
	output reg                    o_int_enable_set,
	output reg  [15:0]            o_data_rdata,
	output reg  [1:0]             o_data_origin,
	output reg                    o_data_blocked,
	output reg                    o_host_rd_ok,
	output reg  [15:0]            o_host_rdata,
	output wire                   o_host_wr_ok,
	output reg                    o_core1_grant,
	output reg                    o_core2_grant,
	output wire                   o_emu_enable,
	output wire                   o_bscan_enable,
	output wire                   o_ram_overlay_enable,
	output wire                   o_rom_in_data_space,
	output wire                   o_micro_mode_eff,
	output wire                   o_test_rom_hit
);
	reg  [15:0]          processor_mode_register_r;
	reg  [PAGE_BITS-1:0] pc_page_extension_r;
	reg  [1:0]           fetch_origin_r;
	reg  [1:0]           sec_opt_r;
	reg  [1:0]           hpw_r;
	reg                  sec_loaded_r;
	reg  [1:0]           fetch_origin_nxt;
	reg  [PAGE_BITS+15:0] fa_nxt;
	reg  [1:0]           rd_class_nxt;
	reg  [8:0]           vector_page_pointer;
	wire                 secure;
	wire                 ram_overlay_enable;

	// region decode used by the fetch and table-access paths
	function [1:0] region;
		input [15:0] a;
		input        rom_on;
		input        ram_on;
		begin
			if (rom_on && a >= ROM_LO)
				region = `ORG_ROM;
			else if (ram_on && a >= SINGLE_ACCESS_RAM_LO && a <= SINGLE_ACCESS_RAM_HI)
				region = `ORG_RAM;
			else
				region = `ORG_EXT;
		end
	endfunction

	// inclusive range test used by the host window checks
	function in_span;
		input [15:0] a;
		input [15:0] lo;
		input [15:0] hi;
		begin
			in_span = (a >= lo) && (a <= hi);
		end
	endfunction

	// one data read judged by where the issuing fetch came from
	function read_refused;
		input [1:0] sec;
		input [1:0] cls;
		input [1:0] org;
		begin
			case (sec)
				`SEC_ROM: begin
					read_refused = (cls == `ORG_ROM) && (org != `ORG_ROM);
				end
				`SEC_ROMRAM: begin
					read_refused = (cls != `ORG_EXT) && (org == `ORG_EXT);
				end
				default: begin
					read_refused = 1'b0;
				end
			endcase
		end
	endfunction

	// only reads are judged; writes never pass through here
	function host_read_allowed;
		input        sec_on;
		input [1:0]  win;
		input [15:0] a;
		begin
			case (win)
				`HPW_DENY: begin
					host_read_allowed = !sec_on;
				end
				`HPW_WIN_A: begin
					host_read_allowed = !sec_on || in_span(a, `HPW_A_LO, `HPW_A_HI);
				end
				`HPW_WIN_B: begin
					host_read_allowed = !sec_on || in_span(a, `HPW_B_LO, `HPW_B_HI);
				end
				default: begin
					host_read_allowed = 1'b1;
				end
			endcase
		end
	endfunction

	// latched once after reset release and never writable, so software cannot change it
	always @(posedge i_clock) begin
		if (i_srst) begin
			sec_loaded_r <= 1'b0;
			sec_opt_r    <= `SEC_NONE;
			hpw_r        <= `HPW_NONE;
		end else if (!sec_loaded_r) begin
			sec_loaded_r <= 1'b1;
			sec_opt_r    <= i_security_option;
			hpw_r        <= i_host_window_sel;
		end
	end

	assign secure         = sec_opt_r != `SEC_NONE;
	assign o_emu_enable   = i_emu_req & ~secure;
	assign o_bscan_enable = 1'b1;
	assign ram_overlay_enable           = processor_mode_register_r[`MODE_RAM_OVERLAY_ENABLE_BIT];
	assign o_ram_overlay_enable = ram_overlay_enable;
	assign o_rom_in_data_space  = processor_mode_register_r[`MODE_ROM_IN_DATA_SPACE_BIT];
	// rom/ram security overrides the pin so rom can never be unmapped
	assign o_micro_mode_eff = (sec_opt_r == `SEC_ROMRAM) ? 1'b0 : i_micro_mode_select;
	assign o_test_rom_hit = i_fetch_req && i_fetch_addr >= `TEST_LO && i_fetch_addr <= `TEST_HI;
	assign o_host_wr_ok   = i_host_wr;

	always @* begin
		vector_page_pointer = processor_mode_register_r[15:`MODE_VECTOR_PAGE_POINTER_LSB];
	end

	// mode register: reset loads vector pointer all ones, overlay clear
	always @(posedge i_clock) begin
		if (i_srst) begin
			processor_mode_register_r <= `MODE_RST;
		end else if (i_mode_wr) begin
			processor_mode_register_r <= i_mode_wdata;
		end
	end

	// far transfers and vectors
	always @* begin
		fa_nxt = i_far_target;
		case (i_far_op)
			`OP_FB:    fa_nxt = i_far_target;
			`OP_FBACC: fa_nxt = i_acc_a;
			`OP_FCALA: fa_nxt = i_acc_a;
			`OP_FCALL: fa_nxt = i_far_target;
			`OP_FRET:  fa_nxt = i_return_addr;
			`OP_FRETE: fa_nxt = i_return_addr;
			default:   fa_nxt = i_far_target;
		endcase
	end

	always @(posedge i_clock) begin
		if (i_srst) begin
			pc_page_extension_r <= {PAGE_BITS{1'b0}};
			o_pc_load           <= 1'b0;
			o_pc_value          <= {(PAGE_BITS+16){1'b0}};
			o_pc_load_delayed   <= 1'b0;
			o_int_enable_set    <= 1'b0;
		end else begin
			o_pc_load         <= 1'b0;
			o_pc_load_delayed <= 1'b0;
			o_int_enable_set  <= 1'b0;
			if (i_vector_take) begin
				o_pc_load  <= 1'b1;
				// hardware reset always uses the fixed page, whatever the pointer holds
				o_pc_value <= {{PAGE_BITS{1'b0}},
					(i_hw_reset_vector ? `VEC_RESET_PAGE : vector_page_pointer),
					(i_hw_reset_vector ? {`VEC_NUM_BITS{1'b0}} : i_vector_num),
					{`VEC_SLOT_BITS{1'b0}}};
				pc_page_extension_r <= {PAGE_BITS{1'b0}};
			end else if (i_far_op != `OP_NONE) begin
				// page and pc move together in both plain and delayed forms
				o_pc_load           <= 1'b1;
				o_pc_load_delayed   <= i_far_delayed;
				o_pc_value          <= fa_nxt;
				pc_page_extension_r <= fa_nxt[PAGE_BITS+15:16];
				o_int_enable_set    <= i_far_op == `OP_FRETE;
			end else if (i_page_wr) begin
				pc_page_extension_r <= i_page_wdata;
			end
		end
	end

	// program address generation
	always @* begin
		fetch_origin_nxt = region(i_fetch_addr, ~o_micro_mode_eff, ram_overlay_enable);
	end

	always @(posedge i_clock) begin
		if (i_srst) begin
			o_prog_addr     <= {(PAGE_BITS+16){1'b0}};
			o_prog_onchip   <= 1'b0;
			o_prog_external <= 1'b0;
			o_prog_is_rom   <= 1'b0;
			o_prog_is_ram   <= 1'b0;
			fetch_origin_r  <= `ORG_EXT;
		end else begin
			o_prog_onchip   <= 1'b0;
			o_prog_external <= 1'b0;
			o_prog_is_rom   <= 1'b0;
			o_prog_is_ram   <= 1'b0;
			if (i_prog_data_rd || i_prog_data_wr) begin
				// table accesses address through accumulator A
				o_prog_addr <= (ram_overlay_enable && i_acc_a[15:0] <= `RAM_ALIAS_HI) ?
					{{PAGE_BITS{1'b0}}, i_acc_a[15:0]} : i_acc_a;
				o_prog_is_ram   <= ram_overlay_enable && i_acc_a[15:0] <= `RAM_ALIAS_HI &&
					i_acc_a[15:0] >= SINGLE_ACCESS_RAM_LO;
				o_prog_is_rom   <= i_acc_a[PAGE_BITS+15:16] == {PAGE_BITS{1'b0}} &&
					~o_micro_mode_eff && i_acc_a[15:0] >= ROM_LO;
				o_prog_onchip   <= region(i_acc_a[15:0], ~o_micro_mode_eff, ram_overlay_enable) != `ORG_EXT;
				o_prog_external <= region(i_acc_a[15:0], ~o_micro_mode_eff, ram_overlay_enable) == `ORG_EXT;
			end else if (i_fetch_req) begin
				fetch_origin_r <= fetch_origin_nxt;
				// lower half of each page folds to page 0 only with overlay set
				o_prog_addr <= (ram_overlay_enable && i_fetch_addr <= `RAM_ALIAS_HI) ?
					{{PAGE_BITS{1'b0}}, i_fetch_addr} :
					{pc_page_extension_r, i_fetch_addr};
				o_prog_onchip   <= fetch_origin_nxt != `ORG_EXT;
				o_prog_external <= fetch_origin_nxt == `ORG_EXT;
				o_prog_is_rom   <= fetch_origin_nxt == `ORG_ROM;
				o_prog_is_ram   <= fetch_origin_nxt == `ORG_RAM;
			end
		end
	end

	// data read security by fetch-origin tag
	always @* begin
		rd_class_nxt = `ORG_EXT;
		if (o_rom_in_data_space && i_data_addr >= ROM_LO)
			rd_class_nxt = `ORG_ROM;
		else if (i_data_addr >= DUAL_ACCESS_RAM_LO && i_data_addr <= SINGLE_ACCESS_RAM_HI)
			rd_class_nxt = `ORG_RAM;
	end

	always @(posedge i_clock) begin
		if (i_srst) begin
			o_data_rdata   <= 16'h0000;
			o_data_origin  <= `ORG_EXT;
			o_data_blocked <= 1'b0;
		end else if (i_data_rd) begin
			o_data_origin <= fetch_origin_r;
			if (read_refused(sec_opt_r, rd_class_nxt, fetch_origin_r)) begin
				o_data_rdata   <= `SECURE_FILL;
				o_data_blocked <= 1'b1;
			end else begin
				o_data_rdata   <= i_mem_rdata;
				o_data_blocked <= 1'b0;
			end
		end else begin
			o_data_blocked <= 1'b0;
		end
	end

	// host-port read window
	always @(posedge i_clock) begin
		if (i_srst) begin
			o_host_rd_ok <= 1'b0;
			o_host_rdata <= 16'h0000;
		end else if (i_host_rd) begin
			if (host_read_allowed(secure, hpw_r, i_host_addr)) begin
				o_host_rd_ok <= 1'b1;
				o_host_rdata <= i_host_mem_rdata;
			end else begin
				o_host_rd_ok <= 1'b0;
				o_host_rdata <= `SECURE_FILL;
			end
		end else begin
			o_host_rd_ok <= 1'b0;
		end
	end

	// shared ram: two independent ports, no arbitration needed
	always @(posedge i_clock) begin
		if (i_srst) begin
			o_core1_grant <= 1'b0;
			o_core2_grant <= 1'b0;
		end else begin
			o_core1_grant <= i_core1_req && i_core1_addr >= SHR_LO && i_core1_addr <= SHR_HI;
			o_core2_grant <= i_core2_req && i_core2_addr >= SHR_LO && i_core2_addr <= SHR_HI;
		end
	end

	// register read port, data one cycle after the strobe
	always @(posedge i_clock) begin
		if (i_srst) begin
			o_mode_rdata <= 16'h0000;
			o_page_rdata <= {PAGE_BITS{1'b0}};
		end else begin
			o_mode_rdata <= i_mode_rd ? processor_mode_register_r : 16'h0000;
			o_page_rdata <= i_page_rd ? pc_page_extension_r : {PAGE_BITS{1'b0}};
		end
	end
endmodule

// ===== tb/map_sec_asserts.sv
// checker for the program memory map, security and vector behaviour
`timescale 1ns/10ps
`include "prog_mem_map.vh"
module map_sec_asserts #(
	parameter PAGE_BITS = 7
) (
	input wire logic                     i_clock,
	input wire logic                     i_srst,
	input wire logic [1:0]               i_security_option,
	input wire logic [1:0]               i_host_window_sel,
	input wire logic                     i_host_rd,
	input wire logic                     i_host_wr,
	input wire logic [15:0]              i_host_addr,
	input wire logic                     i_fetch_req,
	input wire logic                     i_vector_take,
	input wire logic [`VEC_NUM_BITS-1:0] i_vector_num,
	input wire logic                     i_hw_reset_vector,
	input wire logic [2:0]               i_far_op,
	input wire logic [PAGE_BITS+15:0]    i_far_target,
	input wire logic                     o_prog_onchip,
	input wire logic                     o_prog_external,
	input wire logic                     o_pc_load,
	input wire logic [PAGE_BITS+15:0]    o_pc_value,
	input wire logic [15:0]              o_data_rdata,
	input wire logic                     o_data_blocked,
	input wire logic                     o_host_rd_ok,
	input wire logic                     o_host_wr_ok,
	input wire logic                     o_emu_enable,
	input wire logic                     o_bscan_enable,
	input wire logic                     o_micro_mode_eff,
	input wire logic                     o_ram_overlay_enable
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);
	// security is latched after release, so the first edge out of reset is not judged
	wire secured   = i_security_option != `SEC_NONE;
	wire win_a_out = i_host_addr < `HPW_A_LO || i_host_addr > `HPW_A_HI;
	wire win_b_out = i_host_addr < `HPW_B_LO || i_host_addr > `HPW_B_HI;
	wire host_miss = secured && i_host_rd && (i_host_window_sel == `HPW_DENY
		|| i_host_window_sel == `HPW_WIN_A && win_a_out || i_host_window_sel == `HPW_WIN_B && win_b_out);
	sequence hw_vec_req;
		i_vector_take && i_hw_reset_vector;
	endsequence
	sequence hw_vec_load;
		o_pc_load && o_pc_value == {{PAGE_BITS{1'b0}}, `VEC_RESET_PAGE, 5'h00, 2'b00};
	endsequence
	emu_block_a: assert property (!$past(i_srst) && secured |-> !o_emu_enable)
		else $error("emulation open while secured");
	bscan_keep_a: assert property (o_bscan_enable)
		else $error("boundary scan disabled");
	host_write_a: assert property (i_host_wr |-> o_host_wr_ok)
		else $error("host write refused");
	host_refuse_a: assert property (!$past(i_srst) && host_miss |=> !o_host_rd_ok)
		else $error("host read outside window honoured");
	micro_force_a: assert property (!$past(i_srst) && i_security_option == `SEC_ROMRAM |-> !o_micro_mode_eff)
		else $error("microcomputer mode not forced");
	hw_vector_a: assert property (hw_vec_req |=> hw_vec_load)
		else $error("hardware reset vector not at fixed page");
	far_branch_a: assert property (i_far_op == `OP_FB && !i_vector_take |=> o_pc_load && o_pc_value == $past(i_far_target))
		else $error("far branch target not loaded");
	fetch_route_a: assert property (i_fetch_req |=> o_prog_onchip != o_prog_external)
		else $error("fetch routed to both or neither");
	blocked_fill_a: assert property (o_data_blocked |-> o_data_rdata == `SECURE_FILL)
		else $error("blocked read not filled");
	open_data_a: assert property (!$past(i_srst) && !secured |-> !o_data_blocked)
		else $error("read blocked without security");
	overlay_reset_a: assert property ($past(i_srst) |-> !o_ram_overlay_enable)
		else $error("overlay set after reset");
endmodule
bind prog_mem_map map_sec_asserts #(.PAGE_BITS(PAGE_BITS)) u_chk (.*);

// ===== tb/mem_partner.sv
// far-side memory model answering data and host reads from the address
`timescale 1ns/10ps
module mem_partner (
	input  wire logic        i_data_rd,
	input  wire logic [15:0] i_data_addr,
	input  wire logic        i_host_rd,
	input  wire logic [15:0] i_host_addr,
	output logic      [15:0] o_mem_rdata,
	output logic      [15:0] o_host_mem_rdata
);
	// outside a read the bus shows the inverse, so a stale sample never matches
	assign o_mem_rdata      = i_data_rd ? i_data_addr ^ 16'h3C3C : ~(i_data_addr ^ 16'h3C3C);
	assign o_host_mem_rdata = i_host_rd ? i_host_addr ^ 16'h3C3C : ~(i_host_addr ^ 16'h3C3C);
endmodule

// ===== tb/program_memory_map_and_security_tb_top.sv
// self-checking bench for the program memory map and security block
`timescale 1ns/10ps
`include "prog_mem_map.vh"
module program_memory_map_and_security_tb_top;
	logic        i_clock, i_srst, i_micro_mode_select, i_mode_wr, i_mode_rd, i_page_wr, i_page_rd, i_fetch_req;
	logic        i_vector_take, i_hw_reset_vector, i_far_delayed, i_prog_data_rd, i_prog_data_wr, i_data_rd;
	logic        i_host_rd, i_host_wr, i_core1_req, i_core2_req, i_emu_req;
	logic [1:0]  i_security_option, i_host_window_sel, o_data_origin;
	logic [2:0]  i_far_op;
	logic [4:0]  i_vector_num;
	logic [6:0]  i_page_wdata, o_page_rdata;
	logic [15:0] i_mode_wdata, i_fetch_addr, i_data_addr, i_mem_rdata, i_host_addr, i_host_mem_rdata;
	logic [15:0] i_core1_addr, i_core2_addr, o_mode_rdata, o_data_rdata, o_host_rdata;
	logic [22:0] i_far_target, i_acc_a, i_return_addr, o_prog_addr, o_pc_value;
	logic        o_prog_onchip, o_prog_external, o_prog_is_rom, o_prog_is_ram, o_pc_load, o_pc_load_delayed;
	logic        o_int_enable_set, o_data_blocked, o_host_rd_ok, o_host_wr_ok, o_core1_grant, o_core2_grant;
	logic        o_emu_enable, o_bscan_enable, o_ram_overlay_enable, o_rom_in_data_space, o_micro_mode_eff;
	logic        o_test_rom_hit;
	int          err_total, check_count;
	prog_mem_map dut (.*);
	mem_partner mem (.i_data_rd, .i_data_addr, .i_host_rd, .i_host_addr, .o_mem_rdata(i_mem_rdata),
		.o_host_mem_rdata(i_host_mem_rdata));
	always #4 i_clock = ~i_clock;
	task automatic go;
		@(posedge i_clock);
	endtask
	task automatic chk(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask
	// every strobe but i_page_wr and i_prog_data_wr drops together one edge after it was raised
	task automatic fin;
		go;
		{i_mode_wr, i_mode_rd, i_page_rd, i_fetch_req, i_vector_take, i_prog_data_rd} <= '0;
		{i_data_rd, i_host_rd, i_host_wr, i_core1_req, i_core2_req, i_far_op} <= '0;
		#1;
	endtask
	task automatic rst(input logic [1:0] sec, win);
		i_srst <= 1'b1;
		i_security_option <= sec;
		i_host_window_sel <= win;
		repeat (6) go;
		i_srst <= 1'b0;
		go;
		#1;
	endtask
	task automatic pg_wr(input logic [6:0] v);
		go;
		i_page_wr <= 1'b1;
		i_page_wdata <= v;
		go;
		i_page_wr <= 1'b0;
		#1;
	endtask
	task automatic mode_wr(input logic [15:0] v);
		go;
		i_mode_wr <= 1'b1;
		i_mode_wdata <= v;
		fin;
	endtask
	task automatic mode_rd(input logic [15:0] exp);
		go;
		i_mode_rd <= 1'b1;
		fin;
		chk(o_mode_rdata, exp);
	endtask
	task automatic fetch(input logic [15:0] a, input logic ext, rom);
		go;
		i_fetch_req <= 1'b1;
		i_fetch_addr <= a;
		fin;
		chk(o_prog_addr, {7'h00, a});
		chk(o_prog_external, ext);
		chk(o_prog_is_rom, rom);
	endtask
	task automatic dread(input logic [15:0] a, input logic blk);
		go;
		i_data_rd <= 1'b1;
		i_data_addr <= a;
		fin;
		chk(o_data_rdata, blk ? `SECURE_FILL : a ^ 16'h3C3C);
		chk(o_data_blocked, blk);
	endtask
	task automatic hread(input logic [15:0] a, input logic ok);
		go;
		i_host_wr <= 1'b1;
		i_host_addr <= a;
		#1;
		chk(o_host_wr_ok, 1'b1);
		go;
		i_host_wr <= 1'b0;
		i_host_rd <= 1'b1;
		fin;
		chk(o_host_rd_ok, ok);
		chk(o_host_rdata, ok ? a ^ 16'h3C3C : `SECURE_FILL);
	endtask
	task automatic vec(input logic [4:0] n, input logic hw, input logic [22:0] exp);
		go;
		i_vector_take <= 1'b1;
		i_vector_num <= n;
		i_hw_reset_vector <= hw;
		fin;
		chk(o_pc_load, 1'b1);
		chk(o_pc_value, exp);
	endtask
	task automatic far(input logic [2:0] op);
		logic [22:0] exp;
		exp = (op == `OP_FB || op == `OP_FCALL) ? i_far_target : (op < 3'h4) ? i_acc_a : i_return_addr;
		go;
		i_far_op <= op;
		i_far_delayed <= op[0];
		fin;
		chk({o_pc_load, o_pc_load_delayed, o_int_enable_set}, {1'b1, op[0], op == `OP_FRETE});
		chk(o_pc_value, exp);
		go;
		i_page_rd <= 1'b1;
		fin;
		chk(o_page_rdata, exp[22:16]);
	endtask
	task automatic table_rd(input logic [22:0] acc, exp, input logic ext);
		go;
		i_prog_data_rd <= 1'b1;
		i_acc_a <= acc;
		fin;
		chk(o_prog_addr, exp);
		chk(o_prog_external, ext);
	endtask
	task automatic tend(input string name);
		$display("%s finished: checks %0d mismatches %0d", name, check_count, err_total);
	endtask
	task automatic test_done;
		$display("total checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge i_clock);
		err_total++;
		$display("[ERR] %0t run hung", $time);
		test_done;
	end
	initial begin
		{i_clock, i_micro_mode_select, i_page_wr, i_hw_reset_vector, i_far_delayed, i_prog_data_wr} = '0;
		{i_mode_wr, i_mode_rd, i_page_rd, i_fetch_req, i_vector_take, i_prog_data_rd, i_data_rd} = '0;
		{i_host_rd, i_host_wr, i_core1_req, i_core2_req, i_far_op, i_vector_num, i_page_wdata} = '0;
		{i_mode_wdata, i_fetch_addr, i_data_addr, i_host_addr, i_core1_addr, i_core2_addr} = '0;
		{i_far_target, i_acc_a, i_return_addr} = {23'h123456, 23'h234560, 23'h345670};
		i_emu_req = 1'b1;
		err_total = 0;
		check_count = 0;
		rst(`SEC_NONE, `HPW_NONE);
		mode_rd(`MODE_RST);
		chk({o_ram_overlay_enable, o_emu_enable}, 2'b01);
		fetch(16'hC000, 1'b0, 1'b1);
		fetch(16'h0100, 1'b1, 1'b0);
		vec(5'h03, 1'b0, 23'h00FF8C);
		mode_wr(16'h0128);
		fetch(16'h0100, 1'b0, 1'b0);
		vec(5'h01, 1'b0, 23'h000104);
		vec(5'h01, 1'b1, 23'h00FF80);
		table_rd(23'h051234, 23'h001234, 1'b0);
		mode_wr(16'h0108);
		table_rd(23'h051234, 23'h051234, 1'b1);
		hread(16'h6000, 1'b1);
		for (int k = 1; k < 7; k++) far(k[2:0]);
		go;
		{i_core1_req, i_core2_req, i_core1_addr, i_core2_addr} <= {2'b11, 16'h8000, 16'hBFFF};
		fin;
		chk({o_core1_grant, o_core2_grant}, 2'b11);
		pg_wr(7'h5A);
		go;
		i_page_rd <= 1'b1;
		fin;
		chk(o_page_rdata, 7'h5A);
		vec(5'h02, 1'b0, 23'h000108);
		go;
		i_fetch_req <= 1'b1;
		i_fetch_addr <= `TEST_LO;
		#1 chk(o_test_rom_hit, 1'b1);
		fin;
		i_micro_mode_select = 1'b1;
		fetch(16'hE000, 1'b1, 1'b0);
		tend("map");
		i_micro_mode_select = 1'b0;
		rst(`SEC_ROM, `HPW_DENY);
		mode_wr(16'hFF88);
		fetch(16'h0100, 1'b1, 1'b0);
		dread(16'hC000, 1'b1);
		dread(16'h0100, 1'b0);
		fetch(16'hC000, 1'b0, 1'b1);
		dread(16'hC000, 1'b0);
		hread(16'h1000, 1'b0);
		mode_wr(16'hFFA8);
		fetch(16'h0100, 1'b0, 1'b0);
		dread(16'hC000, 1'b1);
		tend("rom");
		i_micro_mode_select = 1'b1;
		rst(`SEC_ROMRAM, `HPW_WIN_A);
		chk({o_micro_mode_eff, o_emu_enable}, 2'b00);
		fetch(16'hC000, 1'b0, 1'b1);
		dread(16'h0100, 1'b0);
		fetch(16'h0100, 1'b1, 1'b0);
		dread(16'h0100, 1'b1);
		hread(16'h17FF, 1'b1);
		hread(16'h1800, 1'b0);
		tend("romram");
		rst(`SEC_ROMRAM, `HPW_WIN_B);
		hread(16'h4000, 1'b1);
		hread(16'h5FFF, 1'b1);
		hread(16'h3FFF, 1'b0);
		tend("window");
		test_done;
	end
endmodule
